//--- hw/lcl_host.sv
// Host end: serialises one frame per request and strobes it in.
// Assumes user holds short_frame stable while busy is high; cmd/seg are captured at start.
`timescale 1ns/1ps
`default_nettype none
module lcl_host (
   input  wire logic                          clk,
   input  wire logic                          reset,
   lcl_link_if.host                           link,
   input  wire logic                          start,
   input  wire logic                          short_frame,
   input  wire logic [lcl_pkg::SEG_BITS-1:0]  seg_data,
   input  wire logic [lcl_pkg::CMD_BITS-1:0]  cmd,
   output logic                               busy,
   output logic                               done
);
   typedef enum logic [3:0] {
      LH_IDLE = 4'b0001,
      LH_LOW  = 4'b0010,
      LH_HIGH = 4'b0100,
      LH_LOAD = 4'b1000
   } lh_state_t;

   lh_state_t state, next_state;
   logic [lcl_pkg::FRAME_BITS-1:0] shreg, next_shreg;
   logic [5:0] bits, next_bits;
   logic [7:0] tmr, next_tmr;
   logic next_sdata, next_sclk, next_load, next_busy, next_done;

   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bits  = bits;
      next_tmr   = tmr;
      next_sdata = link.ser_data;
      next_sclk  = link.ser_clk;
      next_load  = link.latch_strobe;
      next_busy  = busy;
      next_done  = 1'b0;
      case (state)
         LH_IDLE: begin
            if (start) begin
               // Row bits before opcode, so a short frame's four bits land like a full one's
               next_shreg = {seg_data, cmd[lcl_pkg::ROW_SEL_LSB +: 2],
                             cmd[lcl_pkg::OPCODE_LSB +: 4]};
               // A short frame sends only its four opcode bits, a full one all bits; no padding bits are ever needed
               next_bits  = short_frame ? 6'h4 : 6'(lcl_pkg::FRAME_BITS);
               next_tmr   = 8'(lcl_pkg::SER_HALF_CYC - 1);
               next_busy  = 1'b1;
               next_load  = 1'b0;
               next_state = LH_LOW;
            end
         end
         LH_LOW: begin
            // Data must be set up on the pin before serial clock rises
            next_sdata = short_frame ? shreg[lcl_pkg::SR_OPCODE_LSB + 3]
                                     : shreg[lcl_pkg::FRAME_BITS-1];
            next_sclk  = 1'b0;
            if (tmr == 8'h0) begin
               next_tmr   = 8'(lcl_pkg::SER_HALF_CYC - 1);
               next_state = LH_HIGH;
            end else begin
               next_tmr = tmr - 8'h1;
            end
         end
         LH_HIGH: begin
            next_sclk = 1'b1;
            if (tmr == 8'h0) begin
               next_sclk  = 1'b0;
               next_shreg = {shreg[lcl_pkg::FRAME_BITS-2:0], 1'b0};
               next_bits  = bits - 6'h1;
               next_tmr   = 8'(lcl_pkg::SER_HALF_CYC - 1);
               next_state = (bits == 6'h1) ? LH_LOAD : LH_LOW;
            end else begin
               next_tmr = tmr - 8'h1;
            end
         end
         LH_LOAD: begin
            // Wait a half period after last clock, then strobe; no clocks meanwhile
            if (tmr == 8'h0) begin
               if (!link.latch_strobe) begin
                  next_load = 1'b1;
                  next_tmr  = 8'(lcl_pkg::LOAD_CYC - 1);
               end else begin
                  next_load  = 1'b0;
                  next_busy  = 1'b0;
                  next_done  = 1'b1;
                  next_state = LH_IDLE;
               end
            end else begin
               next_tmr = tmr - 8'h1;
            end
         end
         default: next_state = LH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state             <= LH_IDLE;
         shreg             <= '0;
         bits              <= 6'h0;
         tmr               <= 8'h0;
         link.ser_data     <= 1'b0;
         link.ser_clk      <= 1'b0;
         link.latch_strobe <= 1'b0;
         busy              <= 1'b0;
         done              <= 1'b0;
      end else begin
         state             <= next_state;
         shreg             <= next_shreg;
         bits              <= next_bits;
         tmr               <= next_tmr;
         link.ser_data     <= next_sdata;
         link.ser_clk      <= next_sclk;
         link.latch_strobe <= next_load;
         busy              <= next_busy;
         done              <= next_done;
      end
   end
endmodule
`default_nettype wire

//--- hw/lcl_pkg.sv
// Constants shared by both ends of the three-wire LCD command link.
// Assumes both ends run on one 250 MHz system clock.
package lcl_pkg;
   localparam int SEG_BITS      = 32;
   localparam int CMD_BITS      = 6;
   localparam int FRAME_BITS    = SEG_BITS + CMD_BITS;
   localparam int ROWS          = 4;
   localparam logic [3:0] OPC_ROW_WRITE = 4'h2;
   localparam logic [3:0] OPC_BLANK     = 4'hA;
   localparam logic [3:0] OPC_UNBLANK   = 4'hB;
   localparam int ROW_SEL_LSB   = 0;
   localparam int OPCODE_LSB    = 2;
   // Opcode is shifted in last, so a bare four-bit opcode lands where a full frame puts it
   localparam int SR_OPCODE_LSB = 0;
   localparam int SR_ROW_LSB    = 4;
   localparam int FRAME_OSC_PERIODS = 24;
   localparam logic RESET_BLANKED = 1'b1;
   localparam int CLK_PERIOD_NS = 4;
   localparam int SER_HALF_NS   = 280;
   localparam int SER_HALF_CYC  = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_NS       = 200;
   localparam int LOAD_CYC      = (LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- hw/lcl_link_if.sv
// Three-wire serial link between host and LCD command loader.
// Assumes the bench drives clk; all wires are one-way.
`timescale 1ns/1ps
`default_nettype none
interface lcl_link_if (input wire logic clk);
   logic ser_data;
   logic ser_clk;
   logic latch_strobe;
   modport host   (input clk, output ser_data, output ser_clk, output latch_strobe);
   modport device (input clk, input ser_data, input ser_clk, input latch_strobe);
endinterface
`default_nettype wire

//--- hw/lcl_device.sv
// Device end: shift register, command decode, row latches, blanking, frame tick.
// Assumes link pins are asynchronous to clk; osc_in is a slow display clock pin.
`timescale 1ns/1ps
`default_nettype none
module lcl_device #(
   parameter int SEG_W = lcl_pkg::SEG_BITS,
   parameter int NROWS = lcl_pkg::ROWS
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   lcl_link_if.device                  link,
   input  wire logic                   osc_in,
   output logic [NROWS-1:0][SEG_W-1:0] row_seg,
   output logic                        blanked,
   output logic                        frame_tick
);
   localparam int SR_W = SEG_W + lcl_pkg::CMD_BITS;

   logic [3:0] s_d1, s_d2;
   logic [2:0] s_d3;
   logic [SR_W-1:0] sr, next_sr;
   logic [NROWS-1:0][SEG_W-1:0] latch, next_latch;
   logic blank, next_blank;
   logic [4:0] osc_cnt, next_osc_cnt;
   logic next_tick;
   logic [NROWS-1:0][SEG_W-1:0] next_row_seg;

   // Two flops per pin; third stage only for edge finding
   always_ff @(posedge clk) begin
      if (reset) begin
         s_d1 <= 4'h0;
         s_d2 <= 4'h0;
         s_d3 <= 3'h0;
      end else begin
         // Data rides the same two flops as the clock, so both keep in step
         s_d1 <= {link.ser_data, osc_in, link.latch_strobe, link.ser_clk};
         s_d2 <= s_d1;
         s_d3 <= s_d2[2:0];
      end
   end

   wire sclk_rise = s_d2[0] & ~s_d3[0];
   wire load_rise = s_d2[1] & ~s_d3[1];
   wire osc_rise  = s_d2[2] & ~s_d3[2];

   always_comb begin
      logic [lcl_pkg::CMD_BITS-1:0] cmd;
      logic [3:0] opc;
      logic [1:0] row;
      cmd = sr[lcl_pkg::CMD_BITS-1:0];
      opc = cmd[lcl_pkg::SR_OPCODE_LSB +: 4];
      row = cmd[lcl_pkg::SR_ROW_LSB +: 2];
      next_sr    = sr;
      next_latch = latch;
      next_blank = blank;
      if (sclk_rise) begin
         next_sr = {sr[SR_W-2:0], s_d2[3]};
      end
      // Edge of strobe used, so a long high level writes once
      if (load_rise) begin
         case (opc)
            lcl_pkg::OPC_ROW_WRITE: next_latch[row] = sr[SR_W-1:lcl_pkg::CMD_BITS];
            lcl_pkg::OPC_BLANK:     next_blank = 1'b1;
            lcl_pkg::OPC_UNBLANK:   next_blank = 1'b0;
            default:                next_blank = blank;
         endcase
      end
      next_osc_cnt = osc_cnt;
      next_tick    = 1'b0;
      if (osc_rise) begin
         if (osc_cnt == 5'(lcl_pkg::FRAME_OSC_PERIODS - 1)) begin
            next_osc_cnt = 5'h0;
            next_tick    = 1'b1;
         end else begin
            next_osc_cnt = osc_cnt + 5'h1;
         end
      end
      for (int i = 0; i < NROWS; i++) begin
         next_row_seg[i] = next_blank ? '0 : next_latch[i];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sr         <= '0;
         latch      <= '0;
         blank      <= lcl_pkg::RESET_BLANKED;
         osc_cnt    <= 5'h0;
         frame_tick <= 1'b0;
         row_seg    <= '0;
         blanked    <= lcl_pkg::RESET_BLANKED;
      end else begin
         sr         <= next_sr;
         latch      <= next_latch;
         blank      <= next_blank;
         osc_cnt    <= next_osc_cnt;
         frame_tick <= next_tick;
         row_seg    <= next_row_seg;
         blanked    <= next_blank;
      end
   end
endmodule
`default_nettype wire

//--- testbench/lcl_link_monitor.sv
// Checker watching the three-wire link between the host and device ends.
// Assumes one clk domain and instantiation beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module lcl_link_monitor (
   input wire logic clk,
   input wire logic reset,
   input wire logic ser_data,
   input wire logic ser_clk,
   input wire logic latch_strobe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   data_setup_a: assert property ($rose(ser_clk) |-> $stable(ser_data))
      else $error("serial data moved at clock rise");
   data_hold_a: assert property ($rose(ser_clk) |=> $stable(ser_data) [*8])
      else $error("serial data moved after clock rise");
   clk_high_a: assert property ($rose(ser_clk) |=> ser_clk [*8])
      else $error("serial clock high too short");
   clk_low_a: assert property ($fell(ser_clk) |=> !ser_clk [*8])
      else $error("serial clock low too short");
   no_clk_load_a: assert property (latch_strobe |-> !ser_clk)
      else $error("serial clock high during strobe");
   load_width_a: assert property ($fell(latch_strobe) |-> $past(latch_strobe, 25))
      else $error("strobe too short");
   load_gap_a: assert property ($rose(latch_strobe) |-> !$past(ser_clk, 25))
      else $error("strobe too close to clock");
   clk_gap_a: assert property ($rose(ser_clk) |-> !$past(latch_strobe, 25))
      else $error("clock too close to strobe");
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench: host end drives the device end over the link.
// Assumes package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int SW = lcl_pkg::SEG_BITS;
   logic                             clk = 0, reset = 1, start = 0, osc_in = 0, short_frame = 0;
   logic [SW-1:0]                    seg_data = '0;
   logic [lcl_pkg::CMD_BITS-1:0]     cmd = '0;
   logic                             busy, done, blanked, frame_tick, exp_blank = 1;
   logic [lcl_pkg::ROWS-1:0][SW-1:0] row_seg;
   logic [SW-1:0]                    exp_row [lcl_pkg::ROWS];
   logic [3:0]                       off [13] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 12, 13, 14, 15};
   int                               failures = 0, compares = 0, seed = 68851, n;
   always #2 clk = ~clk;
   // Slow display clock: 80 system cycles a period
   always #160 osc_in = ~osc_in;
   lcl_link_if u_lcl_link_if (.clk(clk));
   lcl_host u_lcl_host (.clk(clk), .reset(reset), .link(u_lcl_link_if.host), .start(start),
      .short_frame(short_frame), .seg_data(seg_data), .cmd(cmd), .busy(busy), .done(done));
   lcl_device u_lcl_device (.clk(clk), .reset(reset), .link(u_lcl_link_if.device),
      .osc_in(osc_in), .row_seg(row_seg), .blanked(blanked), .frame_tick(frame_tick));
   lcl_link_monitor u_lcl_link_monitor (.clk(clk), .reset(reset),
      .ser_data(u_lcl_link_if.ser_data), .ser_clk(u_lcl_link_if.ser_clk),
      .latch_strobe(u_lcl_link_if.latch_strobe));
   function automatic logic [SW-1:0] exp_seg(int r);
      return exp_blank ? '0 : exp_row[r];
   endfunction
   task automatic check(input logic [SW-1:0] seen, input logic [SW-1:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic check_rows(input string name);
      for (int r = 0; r < lcl_pkg::ROWS; r++) check(row_seg[r], exp_seg(r), "row");
      check(SW'(blanked), SW'(exp_blank), "blank state");
      $display("test %s done", name);
   endtask
   // Short frames are meant for blank and unblank only
   task automatic send(input logic [3:0] opc, input logic [1:0] row, input logic [SW-1:0] seg);
      int t;
      seg_data = seg;
      cmd = {opc, row};
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      check(SW'(busy), SW'(1'b1), "host busy");
      for (t = 0; t < 20000 && done !== 1'b1; t++) begin
         @(posedge clk);
         #1;
      end
      check(SW'(done), SW'(1'b1), "host done");
      repeat (8) @(posedge clk);
      #1;
      if (opc == lcl_pkg::OPC_ROW_WRITE) exp_row[row] = seg;
      if (opc == lcl_pkg::OPC_BLANK) exp_blank = 1'b1;
      if (opc == lcl_pkg::OPC_UNBLANK) exp_blank = 1'b0;
   endtask
   task automatic end_sim();
      $display("counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #320000;
      failures++;
      end_sim();
   end
   initial begin
      for (n = 0; n < lcl_pkg::ROWS; n++) exp_row[n] = '0;
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      check_rows("reset");
      for (n = 0; n < 4; n++) send(lcl_pkg::OPC_ROW_WRITE, n[1:0], n == 0 ? '1 : $random(seed));
      check_rows("write while blanked");
      send(lcl_pkg::OPC_UNBLANK, 2'($random(seed)), $random(seed));
      check_rows("unblank");
      repeat (2) send(off[$unsigned($random(seed)) % 13], 2'($random(seed)), $random(seed));
      send(4'h3, 2'($random(seed)), $random(seed));
      check_rows("disabled codes");
      send(lcl_pkg::OPC_ROW_WRITE, 2'($random(seed)), $random(seed));
      check_rows("resend after disabled");
      send(lcl_pkg::OPC_BLANK, 2'($random(seed)), $random(seed));
      check_rows("blank");
      send(lcl_pkg::OPC_UNBLANK, 2'($random(seed)), $random(seed));
      check_rows("restore");
      short_frame = 1'b1;
      send(lcl_pkg::OPC_BLANK, 2'($random(seed)), $random(seed));
      check_rows("short blank");
      send(lcl_pkg::OPC_UNBLANK, 2'($random(seed)), $random(seed));
      check_rows("short unblank");
      reset = 1'b1;
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      exp_blank = 1'b1;
      for (n = 0; n < lcl_pkg::ROWS; n++) exp_row[n] = '0;
      check_rows("second reset");
      send(lcl_pkg::OPC_UNBLANK, 2'($random(seed)), $random(seed));
      check_rows("unblank after reset");
      short_frame = 1'b0;
      for (n = 0; n < 4000 && frame_tick !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (frame_tick !== 1'b1 && n < 4000);
      check(SW'(n), SW'(lcl_pkg::FRAME_OSC_PERIODS * 80), "frame tick spacing");
      $display("test frame tick done");
      end_sim();
   end
endmodule
`default_nettype wire
